// ### hw/pwd_pkg.sv
// Package of constants and types for the four-channel PWM D/A block
package pwd_pkg;
  localparam int CHANNELS = 4;
  localparam int DUTY_W = 8;
  localparam int PERIOD_CLKS = 256;
  localparam logic [4:0] ROW_PWM = 5'hF;
  localparam logic [4:0] COL_DUTY_CH0 = 5'h17;
  localparam logic [4:0] COL_DUTY_CH3 = 5'h1A;
  localparam logic [4:0] COL_CONFIG = 5'h12;
  localparam logic [4:0] COL_TEST = 5'h1F;
  localparam int PRESCALE_LSB = 0;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  typedef struct packed {
    logic wr_en;
    logic [4:0] row;
    logic [4:0] col;
    logic [7:0] data;
  } pwd_wr_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } pwd_pins_t;
endpackage

// ### hw/pwd_chan.sv
// One PWM channel: period counter, shadowed duty, open-drain drive
`timescale 1ns/100ps
module pwd_chan #(
  parameter int DUTY_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic [DUTY_W-1:0] duty,
  output logic out,
  output logic oe_n,
  output logic period_start
);
  import pwd_pkg::*;
  logic running;
  logic [DUTY_W-1:0] cnt;
  logic [DUTY_W-1:0] active;
  logic next_running;
  logic [DUTY_W-1:0] next_cnt;
  logic [DUTY_W-1:0] next_active;
  logic high;

  always_comb begin
    next_running = running;
    next_cnt = cnt;
    next_active = active;
    if (tick) begin
      if (!running) begin
        if (start) begin
          next_running = 1'b1;
          next_cnt = '0;
          next_active = duty;
        end
      end else begin
        next_cnt = cnt + 1'b1;
        if (cnt == {DUTY_W{1'b1}}) begin
          next_active = duty;  // RL10
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      cnt <= '0;
      active <= '0;
      out <= 1'b0;
    end else begin
      running <= next_running;
      cnt <= next_cnt;
      active <= next_active;
      out <= high;
    end
  end

  // High for active of 256 prescaled clocks per period
  assign high = running && (cnt < active);  // RL3 RL9
  // Released when high, pulled low otherwise
  assign oe_n = out;  // RL1
  assign period_start = running && tick && (cnt == '0);
endmodule // pwd_chan

// ### hw/pwd_top.sv
// Four-channel 8-bit PWM D/A output block with row/column register writes
//
// Behaviour
// RL1 - Four channels, each an open-drain output that only drives low.
// RL2 - Each channel has its own 8-bit duty register at columns 23 to 26.
// RL3 - High time is N/256 of the period, range 0 to 255/256.
// RL4 - A shared two-bit prescale select sets the period for all channels.
// RL5 - Each channel's period starts one prescaled clock after the previous one.
// RL6 - Columns 27 to 31 of the row carry no PWM function.
// RL7 - Host never writes the test byte at column 31 in normal use.
// RL8 - Select 00,01,10,11 divides the clock by 8,4,2,1; resets to 00.
// RL9 - A period lasts 256 prescaled clocks.
// RL10 - Duties reset to zero; writes take effect at the next period start.
`timescale 1ns/100ps
module pwd_top (
  input wire logic sys_clk,
  input wire logic rst,
  input pwd_pkg::pwd_wr_t wr,
  output pwd_pkg::pwd_pins_t pins,
  output logic [1:0] prescale_sel,
  output logic prescaled_dac_clock,
  output logic [4*8-1:0] duty_flat
);
  import pwd_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [DUTY_W-1:0] duty [CHANNELS];
  logic [DUTY_W-1:0] next_duty [CHANNELS];
  logic [1:0] next_prescale_sel;

  function automatic logic hit(input pwd_wr_t w, input logic [4:0] col);
    hit = w.wr_en && (w.row == ROW_PWM) && (w.col == col);
  endfunction

  always_comb begin
    next_prescale_sel = prescale_sel;
    for (int i = 0; i < CHANNELS; i++) begin
      next_duty[i] = duty[i];
      if (hit(wr, COL_DUTY_CH0 + 5'(i))) begin
        next_duty[i] = wr.data;  // RL2
      end
    end
    // Prescale select lives in the config column, bits 1:0
    if (hit(wr, COL_CONFIG)) begin
      next_prescale_sel = wr.data[PRESCALE_LSB +: 2];  // RL4
    end
    // Columns 27..31 decode to nothing here; the test byte is left to the host
  end  // RL6 RL7

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale_sel <= PRESCALE_RESET;  // RL8
      for (int i = 0; i < CHANNELS; i++) begin
        duty[i] <= DUTY_RESET;  // RL10
      end
    end else begin
      prescale_sel <= next_prescale_sel;
      for (int i = 0; i < CHANNELS; i++) begin
        duty[i] <= next_duty[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      duty_flat[i*8 +: 8] = duty[i];
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  logic [2:0] div;
  logic [2:0] next_div;
  logic [2:0] div_last;
  logic tick;

  always_comb begin
    case (prescale_sel)
      2'h0: div_last = 3'h7;  // RL8
      2'h1: div_last = 3'h3;
      2'h2: div_last = 3'h1;
      2'h3: div_last = 3'h0;
      default: div_last = 3'h7;
    endcase
    tick = (div >= div_last);
    next_div = tick ? 3'h0 : div + 3'h1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      prescaled_dac_clock <= 1'b0;
    end else begin
      div <= next_div;
      prescaled_dac_clock <= tick;
    end
  end

  // ****************************************
  // Channels, staggered start
  // ****************************************
  logic [3:0] started;
  logic [3:0] next_started;
  // Nets, since each bit is driven by a different channel instance
  wire logic [3:0] ps;
  wire logic [3:0] ch_out;
  wire logic [3:0] ch_oe_n;

  always_comb begin
    next_started = started;
    // Each channel starts one prescaled clock after the previous one
    if (tick) begin
      next_started[0] = 1'b1;  // RL5
      for (int i = 1; i < CHANNELS; i++) begin
        if (started[i-1]) begin
          next_started[i] = 1'b1;  // RL5
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      started <= '0;
    end else begin
      started <= next_started;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      pwd_chan #(.DUTY_W(DUTY_W)) u_ch (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .start(next_started[g] && !started[g]),
        .duty(duty[g]),
        .out(ch_out[g]),
        .oe_n(ch_oe_n[g]),
        .period_start(ps[g])
      );
    end
  endgenerate

  assign pins = '{out: ch_out, oe_n: ch_oe_n};

  // ****************************************
  // Checks
  // ****************************************
  chk_stagger_one_tick: assert property (  // RL5
    @(posedge sys_clk) disable iff (rst)
    ps[0] |-> ##[1:8] ps[1])
    else $error("channel 1 period not one tick after channel 0");

  chk_reset_prescale: assert property (  // RL8
    @(posedge sys_clk) $fell(rst) |-> prescale_sel == 2'h0)
    else $error("prescale select not 00 after reset");

  chk_div8_spacing: assert property (  // RL8
    @(posedge sys_clk) disable iff (rst)
    (tick && prescale_sel == 2'h0 && $stable(prescale_sel))
    |=> (!tick || prescale_sel != 2'h0) [*7] ##1 (tick || prescale_sel != 2'h0))
    else $error("divide-by-8 tick spacing wrong");

  chk_div1_every: assert property (  // RL8
    @(posedge sys_clk) disable iff (rst)
    (prescale_sel == 2'h3 && $past(prescale_sel) == 2'h3) |-> tick)
    else $error("divide-by-1 tick missing");

  chk_duty_write: assert property (  // RL2
    @(posedge sys_clk) disable iff (rst)
    hit(wr, COL_DUTY_CH3) |=> duty[3] == $past(wr.data))
    else $error("channel 3 duty write lost");

  chk_reserved_cols: assert property (  // RL6
    @(posedge sys_clk) disable iff (rst)
    (wr.wr_en && wr.col > COL_DUTY_CH3) |=> $stable(duty_flat))
    else $error("reserved column changed a duty");

  chk_zero_low: assert property (  // RL10
    @(posedge sys_clk) disable iff (rst)
    (duty[0] == 8'h00 && $past(duty[0]) == 8'h00 && $past(duty[0], 2) == 8'h00
     && g_ch[0].u_ch.active == 8'h00) |=> !pins.out[0])
    else $error("zero duty output went high");

  chk_open_drain: assert property (  // RL1
    @(posedge sys_clk) disable iff (rst)
    pins.oe_n == pins.out)
    else $error("open-drain enable does not follow level");

  chk_period_256: assert property (  // RL9
    @(posedge sys_clk) disable iff (rst)
    (ps[0] && prescale_sel == 2'h3 && $past(prescale_sel) == 2'h3) |-> ##256 ps[0] || prescale_sel != 2'h3)
    else $error("period not 256 prescaled clocks");
endmodule // pwd_top

// ### bench/pwd_host_model.sv
// Host writer and pull-up load model for the PWM D/A block
`timescale 1ns/100ps
module pwd_host_model (
  input wire logic sys_clk,
  input pwd_pkg::pwd_pins_t pins,
  output pwd_pkg::pwd_wr_t wr,
  output logic [3:0] line
);
  import pwd_pkg::*;
  initial wr = '0;
  // Pull-ups lift each released output; a driven one reads low
  assign line = pins.oe_n;
  task automatic write_reg(input logic [4:0] row, input logic [4:0] col, input logic [7:0] data);
    if (col != COL_TEST) begin
      @(posedge sys_clk);
      wr <= '{1'b1, row, col, data};
      @(posedge sys_clk);
      wr.wr_en <= 1'b0;
    end
  endtask
endmodule // pwd_host_model

// ### bench/four_channel_pwm_dac_bench.sv
// Self-checking bench for the four-channel PWM D/A block
`timescale 1ns/100ps
module four_channel_pwm_dac_bench;
  import pwd_pkg::*;
  logic sys_clk;
  logic rst = 1'b1;
  pwd_wr_t wr;
  pwd_pins_t pins;
  logic [1:0] prescale_sel;
  logic prescaled_dac_clock;
  logic [31:0] duty_flat;
  logic [3:0] line;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 63;
  int div;
  int hi;
  int mdl_duty[4];
  pwd_top dut_u (.sys_clk(sys_clk), .rst(rst), .wr(wr), .pins(pins),
    .prescale_sel(prescale_sel), .prescaled_dac_clock(prescaled_dac_clock),
    .duty_flat(duty_flat));
  pwd_host_model host_u (.sys_clk(sys_clk), .pins(pins), .wr(wr), .line(line));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Ceiling sits well above the longest expected run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mdl_flat();
    mdl_flat = {8'(mdl_duty[3]), 8'(mdl_duty[2]), 8'(mdl_duty[1]), 8'(mdl_duty[0])};
  endfunction
  // Any window of one whole period holds exactly the high time
  task automatic count_high(input int ch, output int n);
    n = 0;
    repeat (256 * div) begin
      @(negedge sys_clk);
      if (line[ch] === 1'b1) n++;
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    cmp_reg(duty_flat, 32'h0);
    cmp_reg(prescale_sel, 32'h0);
    cmp_reg(line, 32'h0);
    for (int s = 0; s < 4; s++) begin
      div = 8 >> s;
      host_u.write_reg(ROW_PWM, COL_CONFIG, 8'(s));
      for (int c = 0; c < 4; c++) begin
        mdl_duty[c] = $random(seed) & 255;
        if (c == s) mdl_duty[c] = (s < 2) ? 0 : 255;
        host_u.write_reg(ROW_PWM, COL_DUTY_CH0 + 5'(c), 8'(mdl_duty[c]));
      end
      @(negedge sys_clk);
      cmp_reg(prescale_sel, 32'(s));
      cmp_reg(duty_flat, mdl_flat());
      repeat (512 * div + 16) @(negedge sys_clk);
      cmp_reg(pins.oe_n, pins.out);
      for (int c = 0; c < 4; c++) begin
        count_high(c, hi);
        cmp_cnt(hi, mdl_duty[c] * div);
      end
      hi = 0;
      repeat (256 * div) begin
        @(negedge sys_clk);
        if (prescaled_dac_clock === 1'b1) hi++;
      end
      cmp_cnt(hi, 256);
    end
    div = 4;
    host_u.write_reg(ROW_PWM, COL_CONFIG, 8'h01);
    for (int c = 0; c < 4; c++) begin
      mdl_duty[c] = 128;
      host_u.write_reg(ROW_PWM, COL_DUTY_CH0 + 5'(c), 8'h80);
    end
    repeat (2100) @(negedge sys_clk);
    for (int c = 1; c < 4; c++) begin
      while (line[c-1] !== 1'b0) @(negedge sys_clk);
      while (line[c-1] !== 1'b1) @(negedge sys_clk);
      hi = 0;
      do begin
        @(negedge sys_clk);
        hi++;
      end while (line[c] !== 1'b1);
      cmp_cnt(hi, div);
    end
    // Reserved columns and a foreign row must leave the duties alone
    for (int col = 27; col < 32; col++) host_u.write_reg(ROW_PWM, 5'(col), 8'hA5);
    host_u.write_reg(5'h10, COL_DUTY_CH0, 8'h3C);
    @(negedge sys_clk);
    cmp_reg(duty_flat, mdl_flat());
    finish_test();
  end
endmodule // four_channel_pwm_dac_bench
